// *** design/sample_sync_timestamp.sv ***
`timescale 1ns/1ps
`include "sst_defs.svh"

// Function
// R01: one to four rates, each with ring
// R02: rate one is base; faster rates rejected
// R03: internal rates land on base instants
// R04: system cycle follows base rate ratio
// R05: rates two-four internal or external sync
// R06: sync edge polarity rising or falling
// R07: debounce at 48 MHz consecutive samples
// R08: ignore edges during minimum interval
// R09: reference pulse clears, count restarts
// R10: sync without reset pulse clears counter
// R11: falling reset edge clears counter
// R12: rising reset edge clears counter
// R13: rate one system time; others selectable
// R14: ring overwrites oldest when full
// R15: ten independent readers per buffer
// R16: 200 MB pool shared, sizes in bytes
// R17: cycle counter counts accepted sync edges
module sample_sync_timestamp (
    input  wire logic                CORE_CLK,
    input  wire logic                RST,
    input  wire logic [2:0]          NUM_RATES,
    input  wire logic [31:0]         BASE_DIV,
    input  wire logic [15:0]         CYCLE_RATIO,
    input  wire logic [2:0][15:0]    RATE_DIV,
    input  wire logic [2:0]          EXT_SYNC,
    input  wire logic [2:0][2:0]     SYNC_SEL,
    input  wire logic [2:0]          SYNC_RISE,
    input  wire logic [2:0][7:0]     DEB_COUNT,
    input  wire logic [2:0][23:0]    MIN_GAP,
    input  wire logic [2:0][2:0]     TS_RST_SEL,
    input  wire logic [2:0][1:0]     TS_MODE,
    input  wire logic [2:0]          TS_SRC_CYC,
    input  wire logic [7:0]          DI_PINS,
    input  wire logic [63:0]         DIST_TIME,
    input  wire logic [3:0][31:0]    SAMPLE_DATA,
    input  wire logic [3:0][27:0]    BUF_SIZE,
    input  wire logic                RD_REQ,
    input  wire logic [1:0]          RD_RATE,
    input  wire logic [3:0]          RD_PORT,
    output logic                     RD_VALID,
    output logic [27:0]              RD_ADDR,
    output logic                     RD_EMPTY,
    output logic                     WR_VALID,
    output logic [1:0]               WR_RATE,
    output logic [27:0]              WR_ADDR,
    output logic [31:0]              WR_DATA,
    output logic [63:0]              WR_STAMP,
    output logic                     BASE_TICK,
    output logic                     SYS_CYCLE,
    output logic                     CFG_ERR,
    output logic                     POOL_ERR
);
    localparam int NR = `SST_NUM_READERS;

    function automatic logic [27:0] ring_next(input logic [27:0] off, input logic [27:0] size);
        logic [28:0] nxt;
        nxt = {1'b0, off} + {1'b0, `SST_REC_BYTES};
        ring_next = (nxt >= {1'b0, size}) ? `SST_ADDR_RESET : nxt[27:0];
    endfunction

    // 48 MHz sampling enable from a fractional accumulator
    logic [7:0] smp_acc_q;
    wire  [7:0] smp_sum = smp_acc_q + `SST_SMP_MHZ;
    wire        smp_en  = smp_sum >= `SST_CORE_MHZ; // [R07]

    // pin synchroniser: three stages, a change counts when stages two and three agree
    logic [7:0] pin_s1_q;
    logic [7:0] pin_s2_q;
    logic [7:0] pin_s3_q;
    logic [7:0] pin_q;
    logic [7:0] pin_prev_q;

    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            smp_acc_q  <= 8'h00;
            pin_s1_q   <= 8'h00;
            pin_s2_q   <= 8'h00;
            pin_s3_q   <= 8'h00;
            pin_q      <= 8'h00;
            pin_prev_q <= 8'h00;
        end else begin
            smp_acc_q  <= smp_en ? smp_sum - `SST_CORE_MHZ : smp_sum;
            pin_s1_q   <= DI_PINS;
            pin_s2_q   <= pin_s1_q;
            pin_s3_q   <= pin_s2_q;
            pin_q      <= (pin_s2_q & pin_s3_q) | (pin_q & (pin_s2_q ^ pin_s3_q));
            pin_prev_q <= pin_q;
        end
    end

    // base rate and system cycle
    logic [31:0] base_cnt_q;
    logic [15:0] cyc_cnt_q;
    wire  [31:0] base_last = (BASE_DIV == 32'h0) ? 32'h0 : BASE_DIV - 32'h1;
    wire         base_tick = (base_cnt_q >= base_last);
    wire  [15:0] cyc_last  = (CYCLE_RATIO == 16'h0) ? 16'h0 : CYCLE_RATIO - 16'h1;
    wire         sys_tick  = base_tick && (cyc_cnt_q >= cyc_last); // [R04]

    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            base_cnt_q <= 32'h0;
            cyc_cnt_q  <= 16'h0;
            BASE_TICK  <= 1'b0;
            SYS_CYCLE  <= 1'b0;
        end else begin
            base_cnt_q <= base_tick ? 32'h0 : base_cnt_q + 32'h1;
            if (base_tick) begin
                cyc_cnt_q <= sys_tick ? 16'h0 : cyc_cnt_q + 16'h1; // [R04]
            end
            BASE_TICK <= base_tick;
            SYS_CYCLE <= sys_tick;
        end
    end

    // slower rates two to four
    logic [15:0]      div_cnt_q [3];
    logic [31:0]      cyc_count_q [3];
    logic [31:0]      cyc_count_d [3];
    logic [2:0]       rate_tick;
    logic [2:0]       rate_on;
    logic [2:0]       rate_bad;
    logic [2:0]       ext_ev;

    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_rate
            sync_if sif ();
            assign sif.level     = pin_q[SYNC_SEL[g]];
            assign sif.sample_en = smp_en;
            assign sif.rise      = SYNC_RISE[g];
            assign sif.deb_count = DEB_COUNT[g];
            assign sif.min_gap   = MIN_GAP[g];
            assign ext_ev[g]     = sif.event_pulse & EXT_SYNC[g];

            sync_cond u_cond (
                .clk (CORE_CLK),
                .rst (RST),
                .s   (sif.cond)
            );

            wire [15:0] dlast = RATE_DIV[g] - 16'h1;
            wire        itick = base_tick && (div_cnt_q[g] >= dlast); // [R03]
            assign rate_on[g]   = (NUM_RATES > 3'(g + 1)) && (NUM_RATES <= `SST_MAX_RATES); // [R01]
            assign rate_bad[g]  = rate_on[g] && !EXT_SYNC[g] && (RATE_DIV[g] == 16'h0); // [R02]
            assign rate_tick[g] = rate_on[g] && !rate_bad[g] && (EXT_SYNC[g] ? ext_ev[g] : itick); // [R05]

            // timestamp reset input conditioning
            wire rl   = pin_q[TS_RST_SEL[g]];
            wire rp   = pin_prev_q[TS_RST_SEL[g]];
            wire rrise = rl & ~rp;
            wire rfall = ~rl & rp;
            sst_pkg::reset_mode_type mode;
            assign mode = sst_pkg::reset_mode_type'(TS_MODE[g]);
            wire clr_now = (mode == sst_pkg::ref_pulse && rrise)  // [R09]
                        || (mode == sst_pkg::ref_fall && rfall)    // [R11]
                        || (mode == sst_pkg::ref_rise && rrise);   // [R12]
            wire gap_clr = (mode == sst_pkg::ref_gap) && ext_ev[g] && !rl; // [R10]
            // a sync in the same cycle as a reference clear still counts as the first one
            assign cyc_count_d[g] = gap_clr ? `SST_CNT_RESET // [R10]
                : clr_now ? (ext_ev[g] ? 32'h1 : `SST_CNT_RESET) // [R09]
                : ext_ev[g] ? cyc_count_q[g] + 32'h1 // [R17]
                : cyc_count_q[g];

            always_ff @(posedge CORE_CLK) begin
                if (RST) begin
                    div_cnt_q[g]   <= 16'h0;
                    cyc_count_q[g] <= `SST_CNT_RESET;
                end else begin
                    if (base_tick) begin
                        div_cnt_q[g] <= itick ? 16'h0 : div_cnt_q[g] + 16'h1;
                    end
                    cyc_count_q[g] <= cyc_count_d[g];
                end
            end

            a_rate_aligned: assert property (@(posedge CORE_CLK) disable iff (RST) // [R03]
                (rate_tick[g] && !EXT_SYNC[g]) |-> base_tick)
                else $error("internal rate instant off the base grid");
            a_gap_clear: assert property (@(posedge CORE_CLK) disable iff (RST) // [R10]
                gap_clr |=> (cyc_count_q[g] == `SST_CNT_RESET))
                else $error("gap sync did not clear cycle counter");
            a_count_step: assert property (@(posedge CORE_CLK) disable iff (RST) // [R17]
                (ext_ev[g] && !gap_clr && !clr_now) |=>
                    (cyc_count_q[g] == $past(cyc_count_q[g]) + 32'h1))
                else $error("cycle counter missed a sync edge");
            a_ref_clear: assert property (@(posedge CORE_CLK) disable iff (RST) // [R11]
                (clr_now && !gap_clr && !ext_ev[g]) |=> (cyc_count_q[g] == `SST_CNT_RESET))
                else $error("reference edge did not clear cycle counter");
        end
    endgenerate

    // buffer layout inside the shared pool
    logic [3:0] buf_on;
    assign buf_on = {rate_on & ~rate_bad, (NUM_RATES != 3'h0)};
    wire [28:0] base1 = {1'b0, BUF_SIZE[0]};
    wire [28:0] base2 = base1 + (buf_on[1] ? {1'b0, BUF_SIZE[1]} : 29'h0);
    wire [28:0] base3 = base2 + (buf_on[2] ? {1'b0, BUF_SIZE[2]} : 29'h0);
    wire [28:0] total = base3 + (buf_on[3] ? {1'b0, BUF_SIZE[3]} : 29'h0);
    wire [3:0][27:0] buf_base = {base3[27:0], base2[27:0], base1[27:0], `SST_ADDR_RESET};
    wire pool_bad = total > `SST_POOL_BYTES; // [R16]
    wire [3:0] tick_all = {rate_tick, base_tick} & buf_on & {4{!pool_bad}};

    // pending writes, one serviced per cycle with rate one first
    logic [3:0]       pend_q;
    logic [3:0][27:0] wptr_q;
    logic [3:0][63:0] stamp_q;
    logic [3:0][31:0] data_q;
    wire  [3:0]       pick = pend_q & ~(pend_q - 4'h1);
    wire  [1:0]       pick_idx = pick[0] ? 2'd0 : pick[1] ? 2'd1 : pick[2] ? 2'd2 : 2'd3;
    logic [3:0][63:0] stamp_src;

    always_comb begin
        stamp_src[0] = DIST_TIME; // [R13]
        for (int i = 1; i < 4; i++) begin
            stamp_src[i] = TS_SRC_CYC[i-1] ? {32'h0, cyc_count_d[i-1]} : DIST_TIME; // [R13]
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            pend_q   <= 4'h0;
            wptr_q   <= '0;
            stamp_q  <= '0;
            data_q   <= '0;
            WR_VALID <= 1'b0;
            WR_RATE  <= 2'd0;
            WR_ADDR  <= `SST_ADDR_RESET;
            WR_DATA  <= 32'h0;
            WR_STAMP <= 64'h0;
        end else begin
            // a new sample wins over the clear of the one just serviced
            pend_q   <= (pend_q & ~pick) | tick_all;
            WR_VALID <= |pend_q;
            for (int i = 0; i < 4; i++) begin
                if (tick_all[i]) begin
                    stamp_q[i] <= stamp_src[i];
                    data_q[i]  <= SAMPLE_DATA[i];
                end
            end
            if (|pend_q) begin
                WR_RATE  <= pick_idx;
                WR_ADDR  <= buf_base[pick_idx] + wptr_q[pick_idx];
                WR_DATA  <= data_q[pick_idx];
                WR_STAMP <= stamp_q[pick_idx];
                wptr_q[pick_idx] <= ring_next(wptr_q[pick_idx], BUF_SIZE[pick_idx]); // [R14]
            end
        end
    end

    // independent readers, each with its own position per buffer
    logic [3:0][NR-1:0][27:0] rptr_q;
    wire        rd_ok    = RD_REQ && (RD_PORT < 4'(NR)) && buf_on[RD_RATE];
    wire [27:0] rd_pos   = rptr_q[RD_RATE][RD_PORT];
    wire        rd_empty = rd_pos == wptr_q[RD_RATE];

    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            rptr_q   <= '0;
            RD_VALID <= 1'b0;
            RD_ADDR  <= `SST_ADDR_RESET;
            RD_EMPTY <= 1'b1;
            CFG_ERR  <= 1'b0;
            POOL_ERR <= 1'b0;
        end else begin
            RD_VALID <= rd_ok && !rd_empty;
            // the empty flag follows the last accepted request only
            if (rd_ok) begin
                RD_EMPTY <= rd_empty;
            end
            if (rd_ok && !rd_empty) begin
                RD_ADDR <= buf_base[RD_RATE] + rd_pos;
                rptr_q[RD_RATE][RD_PORT] <= ring_next(rd_pos, BUF_SIZE[RD_RATE]); // [R15]
            end
            CFG_ERR  <= (|rate_bad) || (NUM_RATES == 3'h0) || (NUM_RATES > `SST_MAX_RATES); // [R02]
            POOL_ERR <= pool_bad; // [R16]
        end
    end

    a_sys_on_base: assert property (@(posedge CORE_CLK) disable iff (RST) // [R04]
        SYS_CYCLE |-> BASE_TICK)
        else $error("system cycle not on a base instant");
    a_wrap_inside: assert property (@(posedge CORE_CLK) disable iff (RST) // [R14]
        (WR_VALID && BUF_SIZE[WR_RATE] >= `SST_REC_BYTES) |->
            (WR_ADDR - buf_base[WR_RATE] < BUF_SIZE[WR_RATE]))
        else $error("write left its ring");
    a_pool_block: assert property (@(posedge CORE_CLK) disable iff (RST) // [R16]
        pool_bad |-> (tick_all == 4'h0))
        else $error("sample stored while pool oversubscribed");
    a_read_empty: assert property (@(posedge CORE_CLK) disable iff (RST) // [R15]
        (RD_REQ && rd_empty) |=> !RD_VALID)
        else $error("read data given from empty reader");
    a_base_stamp: assert property (@(posedge CORE_CLK) disable iff (RST) // [R13]
        (tick_all[0]) |=> (stamp_q[0] == $past(DIST_TIME)))
        else $error("base rate stamped from wrong source");
    a_read_step: assert property (@(posedge CORE_CLK) disable iff (RST) // [R15]
        (rd_ok && !rd_empty) |=> (RD_VALID && !RD_EMPTY))
        else $error("accepted read gave no data");
    a_cycle_stamp: assert property (@(posedge CORE_CLK) disable iff (RST) // [R13]
        (tick_all[1] && TS_SRC_CYC[0]) |=> (stamp_q[1] == {32'h0, $past(cyc_count_d[0])}))
        else $error("rate two stamped from wrong source");
endmodule

// *** design/sync_cond.sv ***
`timescale 1ns/1ps
module sync_cond (
    input wire logic clk,
    input wire logic rst,
    sync_if.cond     s
);
    sst_pkg::cond_state_type state_q;
    sst_pkg::cond_state_type state_d;
    logic [7:0]  deb_q;
    logic [7:0]  deb_d;
    logic [23:0] gap_q;
    logic [23:0] gap_d;
    logic        event_q;
    logic        event_d;

    wire        active   = s.rise ? s.level : ~s.level; // [R06]
    wire [7:0]  deb_need = (s.deb_count == 8'h00) ? 8'h01 : s.deb_count;
    wire [7:0]  deb_inc  = deb_q + 8'h01;
    wire [23:0] gap_inc  = gap_q + 24'h000001;

    always_comb begin
        state_d = state_q;
        deb_d   = deb_q;
        gap_d   = gap_q;
        event_d = 1'b0;
        if (s.sample_en) begin
            case (state_q)
                sst_pkg::wait_idle: begin
                    deb_d = 8'h00;
                    if (!active) begin
                        state_d = sst_pkg::arm;
                    end
                end
                sst_pkg::arm: begin
                    // consecutive matching samples only
                    if (!active) begin
                        deb_d = 8'h00; // [R07]
                    end else if (deb_inc >= deb_need) begin
                        event_d = 1'b1; // [R07]
                        gap_d   = 24'h000000;
                        state_d = sst_pkg::hold;
                    end else begin
                        deb_d = deb_inc;
                    end
                end
                sst_pkg::hold: begin
                    gap_d = gap_inc;
                    if (gap_inc >= s.min_gap) begin
                        state_d = sst_pkg::wait_idle; // [R08]
                    end
                end
                default: begin
                    state_d = sst_pkg::wait_idle;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_q <= sst_pkg::wait_idle;
            deb_q   <= 8'h00;
            gap_q   <= 24'h000000;
            event_q <= 1'b0;
        end else begin
            state_q <= state_d;
            deb_q   <= deb_d;
            gap_q   <= gap_d;
            event_q <= event_d;
        end
    end

    assign s.event_pulse = event_q;

    a_event_single: assert property (@(posedge clk) disable iff (rst) // [R08]
        event_q |-> (state_q == sst_pkg::hold) && !event_d)
        else $error("sync event not followed by hold-off");
    a_event_level: assert property (@(posedge clk) disable iff (rst) // [R07]
        event_d |-> active && s.sample_en && (state_q == sst_pkg::arm))
        else $error("sync event without matching level");
    a_hold_blocks: assert property (@(posedge clk) disable iff (rst) // [R08]
        (state_q == sst_pkg::hold) |-> !event_d)
        else $error("edge accepted during minimum interval");
endmodule

// *** pkg/sst_defs.svh ***
`ifndef SST_DEFS_SVH
`define SST_DEFS_SVH

// timing: core clock and debounce sampling clock, in MHz
`define SST_CORE_MHZ      8'd200
`define SST_SMP_MHZ       8'd48

// ring buffer layout
`define SST_POOL_BYTES    29'd209715200
`define SST_REC_BYTES     28'd16
`define SST_ADDR_W        28
`define SST_NUM_READERS   10
`define SST_MAX_RATES     3'd4

// reset values
`define SST_CNT_RESET     32'h0000_0000
`define SST_ADDR_RESET    28'h000_0000

`endif

// *** pkg/sst_pkg.sv ***
package sst_pkg;

    typedef enum logic [1:0] {
        ref_pulse,
        ref_gap,
        ref_fall,
        ref_rise
    } reset_mode_type;

    typedef enum logic [1:0] {
        wait_idle,
        arm,
        hold
    } cond_state_type;

endpackage

// *** pkg/sync_if.sv ***
`timescale 1ns/1ps
interface sync_if;
    logic        level;
    logic        sample_en;
    logic        rise;
    logic [7:0]  deb_count;
    logic [23:0] min_gap;
    logic        event_pulse;

    modport ctrl (output level, sample_en, rise, deb_count, min_gap, input event_pulse);
    modport cond (input level, sample_en, rise, deb_count, min_gap, output event_pulse);
endinterface

// *** verif/pulse_source.sv ***
`timescale 1ns/1ps
module pulse_source (
    output logic pin
);
    initial begin
        pin = 1'b0;
    end
    task automatic level(input logic v);
        pin = v;
    endtask
    // active phase of the chosen polarity, then back to idle
    task automatic pulse(input logic act, input int w_ns);
        pin = act;
        #(w_ns);
        pin = ~act;
    endtask
endmodule

// *** verif/sample_sync_timestamp_bench.sv ***
`timescale 1ns/1ps
module sample_sync_timestamp_bench;
    logic             clk, rst, rd_req, rd_valid, rd_empty, wr_valid, act;
    logic             base_tick, sys_cycle, cfg_err, pool_err, sync_pin, ref_pin;
    logic [2:0]       num_rates, ext_sync, sync_rise, ts_src_cyc;
    logic [31:0]      base_div, wr_data, rnd;
    logic [15:0]      cycle_ratio;
    logic [2:0][15:0] rate_div;
    logic [2:0][2:0]  sync_sel, ts_rst_sel;
    logic [2:0][7:0]  deb_count;
    logic [2:0][23:0] min_gap;
    logic [2:0][1:0]  ts_mode;
    logic [63:0]      dist_time, wr_stamp;
    logic [3:0][31:0] sample_data;
    logic [3:0][27:0] buf_size;
    logic [1:0]       rd_rate, wr_rate;
    logic [3:0]       rd_port;
    logic [27:0]      rd_addr, wr_addr;
    logic [31:0]      dhist[2];
    logic             prev_wr0;
    int               error_cnt, comparisons, t, last_tick, last_cyc;
    int               off[4];
    int               pos[4][16];
    longint           stamp_q[$];

    sample_sync_timestamp dut (
        .CORE_CLK(clk), .RST(rst), .NUM_RATES(num_rates), .BASE_DIV(base_div),
        .CYCLE_RATIO(cycle_ratio), .RATE_DIV(rate_div), .EXT_SYNC(ext_sync),
        .SYNC_SEL(sync_sel), .SYNC_RISE(sync_rise), .DEB_COUNT(deb_count),
        .MIN_GAP(min_gap), .TS_RST_SEL(ts_rst_sel), .TS_MODE(ts_mode),
        .TS_SRC_CYC(ts_src_cyc), .DI_PINS({2'h0, ref_pin, 1'b0, sync_pin, 3'h0}),
        .DIST_TIME(dist_time), .SAMPLE_DATA(sample_data), .BUF_SIZE(buf_size),
        .RD_REQ(rd_req), .RD_RATE(rd_rate), .RD_PORT(rd_port), .RD_VALID(rd_valid),
        .RD_ADDR(rd_addr), .RD_EMPTY(rd_empty), .WR_VALID(wr_valid), .WR_RATE(wr_rate),
        .WR_ADDR(wr_addr), .WR_DATA(wr_data), .WR_STAMP(wr_stamp),
        .BASE_TICK(base_tick), .SYS_CYCLE(sys_cycle), .CFG_ERR(cfg_err),
        .POOL_ERR(pool_err)
    );
    pulse_source sync_src (.pin(sync_pin));
    pulse_source ref_src (.pin(ref_pin));

    function automatic logic [31:0] xs(input logic [31:0] v);
        v ^= v << 13;
        v ^= v >> 17;
        v ^= v << 5;
        return v;
    endfunction
    function automatic int base_of(input int r);
        int b = 0;
        for (int i = 0; i < r; i++)
            if (i < num_rates) b += buf_size[i];
        return b;
    endfunction
    function automatic int nxt(input int r, input int o);
        return (o + 16 >= buf_size[r]) ? 0 : o + 16;
    endfunction

    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wrap_up();
        $display("comparisons %0d errors %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic reset_dut();
        @(negedge clk);
        rst = 1'b1;
        repeat (5) @(negedge clk);
        rst = 1'b0;
    endtask
    task automatic rd(input int r, input int p);
        logic emp;
        @(negedge clk);
        emp = pos[r][p] == off[r];
        rd_req = 1'b1;
        rd_rate = r[1:0];
        rd_port = p[3:0];
        @(negedge clk);
        rd_req = 1'b0;
        check("rd_valid", rd_valid, p < 10 && !emp);
        if (p < 10) begin
            check("rd_empty", rd_empty, emp);
            if (!emp) begin
                check("rd_addr", rd_addr, base_of(r) + pos[r][p]);
                pos[r][p] = nxt(r, pos[r][p]);
            end
        end
    endtask
    task automatic wait_wr(input int r);
        int n = 0;
        while (!(wr_valid === 1'b1 && wr_rate == r) && n < 5000) begin
            @(posedge clk);
            n++;
        end
        check("wr_seen", n < 5000, 1);
    endtask
    task automatic read_round();
        wait_wr(1);
        for (int i = 0; i < 5; i++) rd(0, 0);
        rd(0, 9);
        rd(0, 10);
        rd(1, 2);
    endtask
    task automatic sp(input longint v);
        stamp_q.push_back(v);
        sync_src.pulse(act, 200);
        #3000;
    endtask
    task automatic cfg(input string what, input logic seen_err, input logic exp);
        repeat (3) @(negedge clk);
        check(what, what == "pool" ? pool_err : cfg_err, exp);
    endtask

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    always @(negedge clk) begin
        rnd = xs(rnd);
        sample_data = {rnd, ~rnd, rnd ^ 32'h5a5a_5a5a, rnd + 32'h1};
        dist_time = dist_time + 64'h1;
    end

    // reference model of the write stream, ring offsets and tick spacing
    always @(posedge clk) begin
        if (rst) begin
            off = '{default: 0};
            pos = '{default: 0};
            t = 0;
            last_tick = 0;
            last_cyc = 0;
        end else begin
            t++;
            if (wr_valid === 1'b1) begin
                check("wr_addr", wr_addr, base_of(wr_rate) + off[wr_rate]);
                off[wr_rate] = nxt(wr_rate, off[wr_rate]);
                if (wr_rate == 2'h0) begin
                    check("wr_stamp0", wr_stamp, dist_time - 64'h2);
                    check("wr_data0", wr_data, dhist[1]);
                end else if (ext_sync[0]) begin
                    check("stamp_pending", stamp_q.size() > 0, 1);
                    if (stamp_q.size() > 0)
                        check("wr_stamp1", wr_stamp, stamp_q.pop_front());
                end else begin
                    check("aligned", prev_wr0, 1);
                    check("wr_stamp1i", wr_stamp, dist_time - 64'h3);
                end
            end
            if (base_tick === 1'b1) begin
                if (last_tick != 0) check("base_period", t - last_tick, base_div);
                last_tick = t;
            end
            if (sys_cycle === 1'b1) begin
                if (last_cyc != 0) check("sys_period", t - last_cyc, base_div * cycle_ratio);
                last_cyc = t;
            end
        end
        prev_wr0 = wr_valid === 1'b1 && wr_rate == 2'h0;
        dhist[1] = dhist[0];
        dhist[0] = sample_data[0];
    end

    initial begin
        #400000;
        error_cnt++;
        wrap_up();
    end

    initial begin
        rst = 1'b1;
        rnd = 32'hed116540;
        {rd_req, rd_rate, rd_port, act} = '0;
        {dist_time, sample_data} = '0;
        num_rates = 3'h2;
        base_div = 32'h28;
        cycle_ratio = 16'h3;
        rate_div = {3{16'h0003}};
        {ext_sync, ts_src_cyc, sync_rise} = {3'h0, 3'h0, 3'h1};
        sync_sel = {3'h0, 3'h0, 3'h3};
        ts_rst_sel = {3{3'h5}};
        deb_count = {3{8'h04}};
        min_gap = {3{24'h000064}};
        ts_mode = 6'h0;
        buf_size = {28'h40, 28'h40, 28'h30, 28'h40};
        reset_dut();
        check("rd_empty_rst", rd_empty, 1);
        check("wr_valid_rst", wr_valid, 0);
        repeat (600) @(negedge clk);
        read_round();
        repeat (300) @(negedge clk);
        read_round();
        base_div = 32'h18;
        reset_dut();
        repeat (500) @(negedge clk);
        base_div = 32'h00ff_ffff;
        reset_dut();
        for (int n = 0; n < 6; n++) begin
            num_rates = n[2:0];
            cfg("rates", cfg_err, n == 0 || n > 4);
        end
        num_rates = 3'h2;
        rate_div[0] = 16'h0;
        cfg("div_zero", cfg_err, 1);
        ext_sync = 3'h1;
        cfg("div_ext", cfg_err, 0);
        buf_size = {28'h640_0000, 28'h640_0000, 28'h640_0010, 28'h640_0000};
        cfg("pool", pool_err, 1);
        buf_size[1] = 28'h640_0000;
        cfg("pool", pool_err, 0);
        buf_size = {28'h40, 28'h40, 28'h30, 28'h40};
        base_div = 32'h28;
        ts_src_cyc = 3'h7;
        for (int m = 0; m < 4; m++) begin
            act = m[0];
            ts_mode = {4'h0, m[1:0]};
            sync_rise = {2'h0, act};
            sync_src.level(~act);
            ref_src.level(m == 1 || m == 2);
            reset_dut();
            // let the pin pipeline fill so the idle level is seen first
            repeat (10) @(negedge clk);
            stamp_q.push_back(1);
            sync_src.pulse(act, 200);
            #300;
            sync_src.pulse(act, 200);
            #2500;
            sync_src.pulse(act, 20);
            #500;
            sp(2);
            if (m == 1) begin
                ref_src.level(1'b0);
                sp(0);
                ref_src.level(1'b1);
            end else if (m == 0)
                ref_src.pulse(1'b1, 200);
            else
                ref_src.level(m == 3);
            #500;
            sp(1);
            check("stamps_left", stamp_q.size(), 0);
        end
        wrap_up();
    end
endmodule
